//--- rtl/stepper_driver_register_set.sv
// Driver register set: configuration, commutation on-time control, status and lost-step count
//
// Function
// R1: Read/write chopper configuration at 0x6C, resets to 0x10410150.
// R2: Write-only 25-bit current and load configuration at 0x6D.
// R3: Write-only commutation control at 0x6E; mode enabled by pin or velocity.
// R4: Bits 9:0 limit PWM on-time for commutation, one clock per count.
// R5: Software sets the on-time limit slightly above the blanking time.
// R6: Bits 23:16 set step-loss on-time in 16-clock units; zero disables.
// R7: Software sets step-loss time slightly above on-time limit over 16.
// R8: Step-loss detection also runs above high velocity with full-step switch.
// R9: Read-only 32-bit driver state at 0x6F: load value and error flags.
// R10: Write-only voltage PWM configuration at 0x70, resets to 0xC40C001E.
// R11: 0x71 bits 7:0 give duty cycle, which scales both phase currents.
// R12: 0x71 bits 24:16 hold signed regulator offset added to duty cycle.
// R13: 0x72 shows automatic offset in bits 7:0, gradient in 23:16.
// R14: 0x73 counts steps arriving while the commutation ready output is low.
// R15: Lost-step counter wraps modulo 2^20.
// R16: Counter follows direction, only with step/direction mode selected.
// R17: Default table entry i is round(248*sin(2*pi*i/1024+pi/1024))-1.
// R18: Default wave peaks at +247 and -248.
// R19: Table rounding takes halves upward.
// R20: Reads of write-only registers return zero and change nothing.
//
// Added by the designer: the plain strobed port.
module stepper_driver_register_set #(
	parameter int ADDR_W = 7,
	parameter int VEL_W  = 23
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0]        reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// Configuration towards the power stage
	output logic      [31:0]              chopper_config,
	output logic      [24:0]              current_load_config,
	output logic      [31:0]              voltage_pwm_config,
	// Status from the power stage and regulator
	input  wire logic [31:0]              driver_status_in,
	input  wire logic [7:0]               calculated_duty,
	input  wire logic [8:0]               regulator_offset,
	input  wire logic [7:0]               auto_offset_value,
	input  wire logic [7:0]               auto_gradient_value,
	input  wire logic [9:0]               microstep_position,
	// Commutation mode control
	input  wire logic                     commutation_enable_pin,
	input  wire logic [VEL_W-1:0]         velocity,
	input  wire logic [VEL_W-1:0]         commutation_min_velocity,
	input  wire logic [VEL_W-1:0]         high_velocity_threshold,
	input  wire logic                     high_velocity_fullstep,
	input  wire logic                     pwm_on,
	// Step input
	input  wire logic                     step_pulse,
	input  wire logic                     step_dir,
	input  wire logic                     step_direction_select,
	// Driver results
	output logic                          commutation_active,
	output logic                          on_time_cut,
	output logic                          commutation_ready_output,
	output logic                          step_loss_detected,
	output logic      [7:0]               actual_duty_cycle,
	output logic      [8:0]               phase_a_current,
	output logic      [8:0]               phase_b_current
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (ADDR_W < 7) begin : g_addr_chk
		$error("ADDR_W must hold offsets up to 0x73");
	end
	if (VEL_W < 1) begin : g_vel_chk
		$error("VEL_W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [31:0]                               chopper_ff;
	logic [drv_regs_pkg::CURRENT_LOAD_W-1:0]   current_load_ff;
	logic [drv_regs_pkg::COMMUTATION_W-1:0]    commutation_ff;
	logic [31:0]                               voltage_pwm_ff;
	logic [drv_regs_pkg::SKIPPED_STEPS_W-1:0]  skipped_steps_ff;
	logic [31:0]                               rdata_ff;
	logic [7:0]                                actual_duty_ff;
	logic [6:0]                                addr7;
	logic                                      addr_hi_zero;

	assign addr7 = reg_addr[6:0];
	if (ADDR_W > 7) begin : g_addr_hi
		assign addr_hi_zero = (reg_addr[ADDR_W-1:7] == '0);
	end else begin : g_addr_lo
		assign addr_hi_zero = 1'b1;
	end

	// Offset match for the write strobes; the read mux decodes addr7 directly
	function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs, input logic hz);
		return hz && (a == ofs);
	endfunction

	// Chopper configuration, the only writable register that also reads back
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			chopper_ff <= drv_regs_pkg::CHOPPER_CONFIG_RST; // R1
		end else if (reg_wr && hit(addr7, drv_regs_pkg::OFS_CHOPPER_CONFIG, addr_hi_zero)) begin
			chopper_ff <= reg_wdata; // R1
		end
	end

	// Current and load configuration, write-only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			current_load_ff <= '0;
		end else if (reg_wr
			&& hit(addr7, drv_regs_pkg::OFS_CURRENT_LOAD_CONFIG, addr_hi_zero)) begin
			current_load_ff <= reg_wdata[drv_regs_pkg::CURRENT_LOAD_W-1:0]; // R2
		end
	end

	// Commutation control, write-only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			commutation_ff <= '0;
		end else if (reg_wr
			&& hit(addr7, drv_regs_pkg::OFS_COMMUTATION_CONTROL, addr_hi_zero)) begin
			commutation_ff <= reg_wdata[drv_regs_pkg::COMMUTATION_W-1:0]; // R3
		end
	end

	// Voltage PWM configuration; upper bits beyond the field width are kept as reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			voltage_pwm_ff <= drv_regs_pkg::VOLTAGE_PWM_CONFIG_RST; // R10
		end else if (reg_wr
			&& hit(addr7, drv_regs_pkg::OFS_VOLTAGE_PWM_CONFIG, addr_hi_zero)) begin
			voltage_pwm_ff[drv_regs_pkg::VOLTAGE_PWM_W-1:0] <=
				reg_wdata[drv_regs_pkg::VOLTAGE_PWM_W-1:0]; // R10
		end
	end

	assign chopper_config      = chopper_ff;
	assign current_load_config = current_load_ff;
	assign voltage_pwm_config  = voltage_pwm_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe
	logic [31:0] nxt_rdata;
	logic [31:0] scale_word;
	logic [31:0] auto_word;

	always_comb begin
		scale_word = '0;
		scale_word[drv_regs_pkg::DUTY_LSB +: 8]       = actual_duty_ff; // R11
		scale_word[drv_regs_pkg::REG_OFFSET_LSB +: 9] = regulator_offset; // R12
		auto_word = '0;
		auto_word[drv_regs_pkg::AUTO_OFS_LSB +: 8]    = auto_offset_value; // R13
		auto_word[drv_regs_pkg::AUTO_GRAD_LSB +: 8]   = auto_gradient_value; // R13
	end

	// Write-only and unmapped offsets read as zero
	always_comb begin
		nxt_rdata = '0;
		if (reg_rd && addr_hi_zero) begin
			unique case (addr7)
				drv_regs_pkg::OFS_CHOPPER_CONFIG: nxt_rdata = chopper_ff; // R1
				drv_regs_pkg::OFS_DRIVER_STATE:   nxt_rdata = driver_status_in; // R9
				drv_regs_pkg::OFS_AMPLITUDE_RESULT: nxt_rdata = scale_word;
				drv_regs_pkg::OFS_AUTO_OFS_GRAD:  nxt_rdata = auto_word;
				drv_regs_pkg::OFS_SKIPPED_STEPS:
					nxt_rdata = {12'h000, skipped_steps_ff}; // R14
				default: nxt_rdata = '0; // R20
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Commutation mode and on-time supervision
	logic [drv_regs_pkg::ON_TIME_LIMIT_W-1:0] on_time_limit;
	logic [drv_regs_pkg::STEP_LOSS_W-1:0]     step_loss_on_time;
	logic [drv_regs_pkg::ON_CNT_W-1:0]        on_cnt_ff;
	logic [drv_regs_pkg::ON_CNT_W-1:0]        limit_cycles;
	logic [drv_regs_pkg::ON_CNT_W-1:0]        loss_cycles;
	logic                                     active_ff;
	logic                                     cut_ff;
	logic                                     ready_ff;
	logic                                     loss_ff;
	logic                                     loss_seen_ff;
	logic                                     pwm_on_d_ff;
	logic                                     loss_enable;

	assign on_time_limit     = commutation_ff[drv_regs_pkg::ON_TIME_LIMIT_LSB +:
		drv_regs_pkg::ON_TIME_LIMIT_W];
	assign step_loss_on_time = commutation_ff[drv_regs_pkg::STEP_LOSS_LSB +:
		drv_regs_pkg::STEP_LOSS_W];
	// Field values scaled to clock periods
	assign limit_cycles = drv_regs_pkg::ON_CNT_W'(on_time_limit
		* drv_regs_pkg::ON_TIME_LIMIT_UNIT); // R4
	assign loss_cycles  = drv_regs_pkg::ON_CNT_W'(step_loss_on_time
		* drv_regs_pkg::STEP_LOSS_UNIT); // R6
	// Zero threshold switches detection off
	assign loss_enable = (step_loss_on_time != '0)
		&& (active_ff || (high_velocity_fullstep
		&& velocity >= high_velocity_threshold)); // R6 R8

	// Mode enable from pin or velocity threshold; zero threshold leaves only the pin
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= commutation_enable_pin
				|| (commutation_min_velocity != '0
				&& velocity >= commutation_min_velocity); // R3
		end
	end

	// On-time counter saturates so a stuck on phase never wraps back under a limit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			on_cnt_ff   <= '0;
			pwm_on_d_ff <= 1'b0;
		end else begin
			pwm_on_d_ff <= pwm_on;
			if (!pwm_on) begin
				on_cnt_ff <= '0;
			end else if (on_cnt_ff != '1) begin
				on_cnt_ff <= on_cnt_ff + 1'b1;
			end
		end
	end

	// On-time cut while the limit is reached in commutation mode
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cut_ff <= 1'b0;
		end else begin
			cut_ff <= active_ff && pwm_on && (on_cnt_ff >= limit_cycles); // R4
		end
	end

	// Ready drops on a cut and recovers when the next on phase starts
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ready_ff <= 1'b1;
		end else if (!active_ff) begin
			ready_ff <= 1'b1;
		end else if (pwm_on && on_cnt_ff >= limit_cycles) begin
			ready_ff <= 1'b0; // R4
		end else if (pwm_on && !pwm_on_d_ff) begin
			ready_ff <= 1'b1;
		end
	end

	// One pulse per on phase that outlasts the step-loss time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			loss_ff      <= 1'b0;
			loss_seen_ff <= 1'b0;
		end else begin
			loss_ff <= 1'b0;
			if (!pwm_on) begin
				loss_seen_ff <= 1'b0;
			end else if (loss_enable && !loss_seen_ff && on_cnt_ff >= loss_cycles) begin
				loss_ff      <= 1'b1; // R6 R8
				loss_seen_ff <= 1'b1;
			end
		end
	end

	assign commutation_active       = active_ff;
	assign on_time_cut              = cut_ff;
	assign commutation_ready_output = ready_ff;
	assign step_loss_detected       = loss_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Lost-step counter: wraps freely, direction sets the sign
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			skipped_steps_ff <= '0;
		end else if (step_direction_select && active_ff && !ready_ff && step_pulse) begin
			if (step_dir) begin
				skipped_steps_ff <= skipped_steps_ff + 1'b1; // R14 R15 R16
			end else begin
				skipped_steps_ff <= skipped_steps_ff - 1'b1; // R15 R16
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Duty cycle: calculated value plus signed regulator offset, clamped to 0..255
	logic signed [9:0] duty_sum;

	assign duty_sum = $signed({2'b00, calculated_duty})
		+ $signed({regulator_offset[8], regulator_offset}); // R12

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			actual_duty_ff <= '0;
		end else if (duty_sum < 0) begin
			actual_duty_ff <= '0;
		end else if (duty_sum > $signed({2'b00, drv_regs_pkg::DUTY_MAX})) begin
			actual_duty_ff <= drv_regs_pkg::DUTY_MAX; // R11
		end else begin
			actual_duty_ff <= duty_sum[7:0];
		end
	end

	assign actual_duty_cycle = actual_duty_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Default quarter-wave table, built at elaboration
	function automatic logic [7:0] sine_default(input int idx);
		real x;
		int  r;
		x = drv_regs_pkg::SINE_AMPLITUDE * $sin(2.0 * drv_regs_pkg::PI
			* real'(idx) / drv_regs_pkg::SINE_PERIOD
			+ drv_regs_pkg::PI / drv_regs_pkg::SINE_PERIOD); // R17
		r = int'($floor(x + 0.5)); // R19
		return 8'(r - 1); // R17
	endfunction

	logic [7:0] sine_rom [drv_regs_pkg::SINE_ENTRIES];

	for (genvar g = 0; g < drv_regs_pkg::SINE_ENTRIES; g++) begin : g_rom
		assign sine_rom[g] = sine_default(g); // R17
	end

	// Full wave from the quarter: mirrored index, negative half is -entry-1
	function automatic logic signed [8:0] wave_at(input logic [9:0] pos);
		logic [7:0] idx;
		logic [7:0] mag;
		idx = pos[8] ? ~pos[7:0] : pos[7:0];
		mag = sine_rom[idx];
		return pos[9] ? -$signed({1'b0, mag}) - 9'sd1 : $signed({1'b0, mag}); // R18
	endfunction

	// Phase currents scaled by the duty cycle; B leads A by a quarter wave
	logic signed [8:0]  wave_a;
	logic signed [8:0]  wave_b;
	logic signed [17:0] prod_a;
	logic signed [17:0] prod_b;
	logic [8:0]         phase_a_ff;
	logic [8:0]         phase_b_ff;

	assign wave_a = wave_at(microstep_position);
	assign wave_b = wave_at(microstep_position + 10'h100);
	assign prod_a = wave_a * $signed({1'b0, actual_duty_ff}); // R11
	assign prod_b = wave_b * $signed({1'b0, actual_duty_ff}); // R11

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			phase_a_ff <= '0;
			phase_b_ff <= '0;
		end else begin
			phase_a_ff <= prod_a[16:8];
			phase_b_ff <= prod_b[16:8];
		end
	end

	assign phase_a_current = phase_a_ff;
	assign phase_b_current = phase_b_ff;

endmodule

//--- rtl/drv_regs_pkg.sv
// Package: offsets, reset values, field positions and timing counts of the driver register set
package drv_regs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [6:0] OFS_CHOPPER_CONFIG      = 7'h6C;
	localparam logic [6:0] OFS_CURRENT_LOAD_CONFIG = 7'h6D;
	localparam logic [6:0] OFS_COMMUTATION_CONTROL = 7'h6E;
	localparam logic [6:0] OFS_DRIVER_STATE        = 7'h6F;
	localparam logic [6:0] OFS_VOLTAGE_PWM_CONFIG  = 7'h70;
	localparam logic [6:0] OFS_AMPLITUDE_RESULT    = 7'h71;
	localparam logic [6:0] OFS_AUTO_OFS_GRAD       = 7'h72;
	localparam logic [6:0] OFS_SKIPPED_STEPS       = 7'h73;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and reset values
	localparam int          CURRENT_LOAD_W        = 25;
	localparam int          COMMUTATION_W         = 24;
	localparam int          VOLTAGE_PWM_W         = 22;
	localparam int          SKIPPED_STEPS_W       = 20;
	localparam logic [31:0] CHOPPER_CONFIG_RST    = 32'h10410150;
	localparam logic [31:0] VOLTAGE_PWM_CONFIG_RST = 32'hC40C001E;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int ON_TIME_LIMIT_LSB   = 0;
	localparam int ON_TIME_LIMIT_W     = 10;
	localparam int STEP_LOSS_LSB       = 16;
	localparam int STEP_LOSS_W         = 8;
	localparam int DUTY_LSB            = 0;
	localparam int REG_OFFSET_LSB      = 16;
	localparam int AUTO_OFS_LSB        = 0;
	localparam int AUTO_GRAD_LSB       = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: on-time units in clock periods
	localparam real CLOCK_PERIOD_NS     = 4.0;
	localparam int  ON_TIME_LIMIT_UNIT  = 1;
	localparam int  STEP_LOSS_UNIT      = 16;
	localparam int  ON_CNT_W            = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Default sine table
	localparam real SINE_AMPLITUDE      = 248.0;
	localparam real SINE_PERIOD         = 1024.0;
	localparam real PI                  = 3.14159265358979;
	localparam int  SINE_ENTRIES        = 256;
	localparam logic [7:0] DUTY_MAX     = 8'hFF;

endpackage

//--- verification/stepper_driver_register_set_checker.sv
// Checker: register port timing, write-only reads, duty clamp, mode and on-time limit
module stepper_driver_register_set_checker #(
	parameter int ADDR_W = 7,
	parameter int VEL_W  = 23
) (
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic [31:0]       chopper_config,
	input wire logic [31:0]       voltage_pwm_config,
	// Status and mode inputs
	input wire logic [31:0]       driver_status_in,
	input wire logic [7:0]        calculated_duty,
	input wire logic [8:0]        regulator_offset,
	input wire logic              commutation_enable_pin,
	input wire logic [VEL_W-1:0]  velocity,
	input wire logic [VEL_W-1:0]  commutation_min_velocity,
	input wire logic              pwm_on,
	// Results
	input wire logic              commutation_active,
	input wire logic              on_time_cut,
	input wire logic [7:0]        actual_duty_cycle
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [9:0]  lim_ff;
	logic [11:0] cnt_ff;
	////////////////////////////////////////
	// Shadow of the on-time limit, since the register itself cannot be read back
	always_ff @(posedge clock) begin
		if (!rst_n)
			lim_ff <= 10'h000;
		else if (reg_wr && reg_addr == drv_regs_pkg::OFS_COMMUTATION_CONTROL)
			lim_ff <= reg_wdata[9:0];
	end
	// Length of the running on phase, saturating like the design's counter
	always_ff @(posedge clock) begin
		if (!rst_n || !pwm_on)
			cnt_ff <= 12'h000;
		else if (cnt_ff != 12'hFFF)
			cnt_ff <= cnt_ff + 12'h001;
	end
	function automatic logic [7:0] sat(input logic [7:0] d, input logic [8:0] o);
		logic signed [10:0] s;
		s = $signed({3'h0, d}) + $signed({{2{o[8]}}, o});
		return (s < 0) ? 8'h00 : ((s > 255) ? 8'hFF : s[7:0]);
	endfunction
	sequence rd_s(logic [6:0] a);
		reg_rd && reg_addr == a;
	endsequence
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	chop_write_a: assert property (reg_wr && reg_addr == 7'h6C |=> chopper_config == $past(reg_wdata))
		else $error("chopper config write lost");
	wo_read_a: assert property (rd_s(7'h6D) or rd_s(7'h6E) or rd_s(7'h70) |=> reg_rdata == 32'h0)
		else $error("write-only register read not zero");
	state_read_a: assert property (rd_s(7'h6F) |=> reg_rdata == $past(driver_status_in))
		else $error("driver state read wrong");
	pwm_top_a: assert property (voltage_pwm_config[31:22] == 10'h310)
		else $error("voltage pwm upper bits changed");
	duty_sum_a: assert property ($past(rst_n) |->
		actual_duty_cycle == sat($past(calculated_duty), $past(regulator_offset)))
		else $error("duty cycle sum wrong");
	mode_on_a: assert property ($past(rst_n) |-> commutation_active == ($past(commutation_enable_pin)
		|| ($past(commutation_min_velocity) != 0
		&& $past(velocity) >= $past(commutation_min_velocity))))
		else $error("commutation mode wrong");
	cut_time_a: assert property ($past(rst_n) |->
		on_time_cut == ($past(commutation_active) && $past(pwm_on)
		&& $past(cnt_ff) >= {2'h0, $past(lim_ff)}))
		else $error("on-time cut at wrong cycle");
endmodule

bind stepper_driver_register_set stepper_driver_register_set_checker #(.ADDR_W(ADDR_W),
	.VEL_W(VEL_W)) u_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.chopper_config, .voltage_pwm_config, .driver_status_in, .calculated_duty, .regulator_offset,
	.commutation_enable_pin, .velocity, .commutation_min_velocity, .pwm_on, .commutation_active,
	.on_time_cut, .actual_duty_cycle);

//--- verification/power_stage_model.sv
// Power stage and regulator model: status word, duty, offset and on-phase signal
module power_stage_model (
	// Towards the register set
	output logic [31:0] driver_status_in,
	output logic [7:0]  calculated_duty,
	output logic [8:0]  regulator_offset,
	output logic [7:0]  auto_offset_value,
	output logic [7:0]  auto_gradient_value,
	output logic        pwm_on
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////
	// Fixed status and auto values; the on phase stays off until commanded
	initial begin
		driver_status_in = 32'h5C3A96E1;
		auto_offset_value = 8'h3B;
		auto_gradient_value = 8'hC4;
		calculated_duty = 8'h00;
		regulator_offset = 9'h000;
		pwm_on = 1'b0;
	end
	// Regulator result, called right after a clock edge
	task automatic set_duty(input logic [7:0] d, input logic [8:0] o);
		calculated_duty <= d;
		regulator_offset <= o;
	endtask
	// On phase of the bridge, called right after a clock edge
	task automatic set_pwm(input logic v);
		pwm_on <= v;
	endtask
endmodule

//--- verification/stepper_driver_register_set_tb_top.sv
// Testbench: register access, on-time limits, lost-step count and wave output
module stepper_driver_register_set_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, reg_wr, reg_rd, pwm_on, commutation_enable_pin;
	logic        high_velocity_fullstep, step_pulse, step_dir, step_direction_select;
	logic        commutation_active, on_time_cut, commutation_ready_output, step_loss_detected;
	logic [6:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, chopper_config, voltage_pwm_config, driver_status_in;
	logic [24:0] current_load_config;
	logic [22:0] velocity, commutation_min_velocity, high_velocity_threshold;
	logic [9:0]  microstep_position;
	logic [7:0]  calculated_duty, auto_offset_value, auto_gradient_value, actual_duty_cycle;
	logic [8:0]  regulator_offset, phase_a_current, phase_b_current;
	int          n_fail, check_count;
	stepper_driver_register_set uut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .chopper_config, .current_load_config, .voltage_pwm_config, .driver_status_in,
		.calculated_duty, .regulator_offset, .auto_offset_value, .auto_gradient_value,
		.microstep_position, .commutation_enable_pin, .velocity, .commutation_min_velocity,
		.high_velocity_threshold, .high_velocity_fullstep, .pwm_on, .step_pulse, .step_dir,
		.step_direction_select, .commutation_active, .on_time_cut, .commutation_ready_output,
		.step_loss_detected, .actual_duty_cycle, .phase_a_current, .phase_b_current);
	power_stage_model ps (.driver_status_in, .calculated_duty, .regulator_offset,
		.auto_offset_value, .auto_gradient_value, .pwm_on);
	////////////////////////////////////////
	// Clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Bus cycles: every task starts and ends right after a rising edge
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		// Let an edge pass so a following write never re-raises the strobe in this step
		@(posedge clock);
	endtask
	task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 check(what, reg_rdata, exp);
		@(posedge clock);
	endtask
	// Expected phase current at full duty; halves round upward via floor(x+0.5)
	function automatic logic [8:0] cur(input int p);
		int q, e;
		q = p % 256;
		if ((p / 256) % 2 == 1)
			q = 255 - q;
		e = $rtoi($floor(248.0 * $sin(6.283185307 * q / 1024.0 + 3.14159265 / 1024.0) + 0.5)) - 1;
		if (p >= 512)
			e = -e - 1;
		return 9'((e * 255) >>> 8);
	endfunction
	////////////////////////////////////////
	task automatic t_config;
		rd(7'h6C, 32'h10410150, "chop reset");
		check("pwm reset", voltage_pwm_config, 32'hC40C001E);
		wr(7'h6C, 32'h5A5A0F0F);
		rd(7'h6C, 32'h5A5A0F0F, "chop rw");
		wr(7'h6D, 32'hFFFFFFFF);
		rd(7'h6D, 32'h00000000, "clc read");
		check("clc", {7'h00, current_load_config}, 32'h01FFFFFF);
		wr(7'h70, 32'h00000000);
		rd(7'h70, 32'h00000000, "pwm read");
		check("pwm wo", voltage_pwm_config, 32'hC4000000);
		wr(7'h71, 32'hFFFFFFFF);
		wr(7'h10, 32'hFFFFFFFF);
		rd(7'h10, 32'h00000000, "unmapped");
	endtask
	// Regulator results; the sum is clamped at both ends
	task automatic t_status;
		logic [7:0] d [3] = '{8'hF0, 8'h10, 8'h80};
		logic [8:0] o [3] = '{9'h01E, 9'h1E2, 9'h000};
		logic [7:0] e [3] = '{8'hFF, 8'h00, 8'h80};
		rd(7'h6F, driver_status_in, "state");
		for (int k = 0; k < 3; k++) begin
			ps.set_duty(d[k], o[k]);
			tick(2);
			rd(7'h71, {7'h00, o[k], 8'h00, e[k]}, "scale");
		end
		rd(7'h72, {8'h00, auto_gradient_value, 8'h00, auto_offset_value}, "auto");
	endtask
	task automatic t_wave;
		int p [4] = '{255, 767, 0, 384};
		ps.set_duty(8'hFF, 9'h000);
		foreach (p[k]) begin
			microstep_position <= 10'(p[k]);
			tick(3);
			check("phase a", {23'h0, phase_a_current}, {23'h0, cur(p[k])});
			check("phase b", {23'h0, phase_b_current}, {23'h0, cur((p[k] + 256) % 1024)});
		end
	endtask
	// Modes: pin, velocity, full-step switch only, pin with loss detection off
	task automatic t_ontime;
		int c, l;
		for (int m = 0; m < 4; m++) begin
			commutation_enable_pin <= (m == 0 || m == 3);
			commutation_min_velocity <= (m == 1) ? 23'h000100 : 23'h000000;
			high_velocity_fullstep <= (m == 2);
			wr(7'h6E, (m == 3) ? 32'h00000003 : 32'h00010003);
			ps.set_pwm(1'b1);
			c = 0;
			l = 0;
			for (int k = 1; k <= 40; k++) begin
				@(posedge clock);
				#1;
				if (on_time_cut === 1'b1 && c == 0)
					c = k;
				if (step_loss_detected === 1'b1)
					l++;
			end
			@(posedge clock);
			ps.set_pwm(1'b0);
			tick(2);
			check("cut edge", c, (m == 2) ? 0 : 4);
			check("loss pulses", l, (m == 3) ? 0 : 1);
		end
	endtask
	task automatic step(input logic d, input logic s);
		step_dir <= d;
		step_direction_select <= s;
		step_pulse <= 1'b1;
		@(posedge clock);
		step_pulse <= 1'b0;
		@(posedge clock);
	endtask
	// Steps keep coming while the ready output is low after a cut
	task automatic t_lost;
		check("ready low", {31'h0, commutation_ready_output}, 32'h0);
		repeat (3) step(1'b1, 1'b1);
		rd(7'h73, 32'h00000003, "steps up");
		repeat (5) step(1'b0, 1'b1);
		rd(7'h73, 32'h000FFFFE, "steps wrap");
		step(1'b1, 1'b0);
		rd(7'h73, 32'h000FFFFE, "sd off");
	endtask
	task automatic test_done;
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		test_done();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{reg_wr, reg_rd, commutation_enable_pin, high_velocity_fullstep} = 4'h0;
		{step_pulse, step_dir, step_direction_select} = 3'h0;
		reg_addr = 7'h00;
		reg_wdata = 32'h0;
		velocity = 23'h000200;
		commutation_min_velocity = 23'h000000;
		high_velocity_threshold = 23'h000180;
		microstep_position = 10'h000;
		n_fail = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("ready reset", {31'h0, commutation_ready_output}, 32'h1);
		t_config();
		t_status();
		t_wave();
		t_ontime();
		t_lost();
		test_done();
	end
endmodule
